// >>> verilog/dprw_pkg.sv
/*
 * package for the dac power-up/brown-out reset and wiper state block:
 * default values, widths and state encodings.
 * assumes a single 10 MHz clock domain.
 */
`default_nettype none
package dprw_pkg;
	localparam int WIPER_W = 7;
	localparam logic [6:0] SHIFT_DEFAULT = 7'h40;
	localparam logic [6:0] WIPER_DEFAULT = 7'h20;
	typedef enum logic [1:0] {
		DPRW_OFF,
		DPRW_LOAD,
		DPRW_STATIC,
		DPRW_ACTIVE
	} dprw_state_t;
endpackage
`default_nettype wire

// >>> verilog/dprw_top.sv
/*
 * power-up and brown-out reset sequencer with the volatile serial shift
 * register and output tap setting register of a small serial dac.
 * assumes an external bus slave supplies start/stop pulses, shifted bits and
 * wiper write strobes on mclk_in; power-good arrives asynchronously.
 */
// Functional notes
// - on power-good, shift register loads 40h and wiper register 20h
// - after the default load the block accepts serial transactions
// - wiper setting kept in a 7-bit volatile register
// - a stop condition puts the block in static operation
// - a start condition makes the serial interface active
// - below retention level register contents are not guaranteed
// - a write cut by brown-out may leave an undefined value
// - supply recovery repeats the full power-on sequence
// - output code follows the last value written to the wiper register
`timescale 1ns/10ps
`default_nettype none
module dprw_top #(
	parameter int WIPER_W = dprw_pkg::WIPER_W
) (
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic start_seen_in,
	input wire logic stop_seen_in,
	input wire logic shift_en_in,
	input wire logic shift_bit_in,
	input wire logic wiper_wr_in,
	input wire logic [WIPER_W-1:0] wiper_data_in,
	input wire logic sda_drive_low_in,
	output logic [WIPER_W-1:0] serial_shift_register_out,
	output logic [WIPER_W-1:0] output_tap_setting_out,
	output logic [WIPER_W-1:0] dac_code_out,
	output logic serial_enable_out,
	output logic interface_active_out,
	output logic sda_out,
	output logic sda_oe_out
);
	dprw_pkg::dprw_state_t state_q, state_d;
	logic [WIPER_W-1:0] shift_q, shift_d;
	logic [WIPER_W-1:0] wiper_q, wiper_d;
	logic serial_ok;
	logic load_now;
	logic [WIPER_W-2:0] shift_keep;

	// resetn_in is the active-low power-good; it clears everything without the clock
	assign load_now = (state_q == dprw_pkg::DPRW_OFF);
	assign serial_ok = (state_q == dprw_pkg::DPRW_STATIC) || (state_q == dprw_pkg::DPRW_ACTIVE);
	// oldest bit falls off the top as the new one enters at bit 0
	assign shift_keep = shift_q[WIPER_W-2:0];

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			dprw_pkg::DPRW_OFF: state_d = dprw_pkg::DPRW_LOAD;
			dprw_pkg::DPRW_LOAD: state_d = dprw_pkg::DPRW_STATIC;
			dprw_pkg::DPRW_STATIC: begin
				if (start_seen_in) begin
					state_d = dprw_pkg::DPRW_ACTIVE;
				end
			end
			dprw_pkg::DPRW_ACTIVE: begin
				// stop wins if both arrive together: the bus ends idle
				if (stop_seen_in) begin
					state_d = dprw_pkg::DPRW_STATIC;
				end
			end
		endcase
	end

	// defaults are loaded in the first clock after power-good; bus inputs are
	// ignored until then, so an interrupted write can never half-land
	always_comb begin
		shift_d = shift_q;
		wiper_d = wiper_q;
		if (load_now) begin
			shift_d = WIPER_W'(dprw_pkg::SHIFT_DEFAULT);
			wiper_d = WIPER_W'(dprw_pkg::WIPER_DEFAULT);
		end else if (serial_ok) begin
			if (shift_en_in) begin
				shift_d = {shift_keep, shift_bit_in};
			end
			if (wiper_wr_in) begin
				wiper_d = wiper_data_in;
			end
		end
	end

	// registers hold only while powered; reset constant stands in for the lost contents
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q <= dprw_pkg::DPRW_OFF;
			shift_q <= '0;
			wiper_q <= '0;
		end else begin
			state_q <= state_d;
			shift_q <= shift_d;
			wiper_q <= wiper_d;
		end
	end

	assign serial_shift_register_out = shift_q;
	assign output_tap_setting_out = wiper_q;
	assign dac_code_out = wiper_q;
	assign serial_enable_out = serial_ok;
	assign interface_active_out = (state_q == dprw_pkg::DPRW_ACTIVE);
	assign sda_out = 1'b0;
	assign sda_oe_out = serial_ok && sda_drive_low_in;

	sequence s_load;
		state_q == dprw_pkg::DPRW_OFF ##1 state_q == dprw_pkg::DPRW_LOAD;
	endsequence

	property p_defaults;
		@(posedge mclk_in) disable iff (!resetn_in)
		s_load |-> shift_q == dprw_pkg::SHIFT_DEFAULT && wiper_q == dprw_pkg::WIPER_DEFAULT;
	endproperty
	a_defaults: assert property (p_defaults) else $error("defaults not loaded");

	property p_ready;
		@(posedge mclk_in) disable iff (!resetn_in)
		s_load |=> serial_enable_out && !interface_active_out;
	endproperty
	a_ready: assert property (p_ready) else $error("interface not enabled after load");

	property p_stop;
		@(posedge mclk_in) disable iff (!resetn_in)
		interface_active_out && stop_seen_in |=> !interface_active_out;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not enter static");

	property p_start;
		@(posedge mclk_in) disable iff (!resetn_in)
		serial_enable_out && !interface_active_out && start_seen_in |=> interface_active_out;
	endproperty
	a_start: assert property (p_start) else $error("start did not activate");

	property p_write;
		@(posedge mclk_in) disable iff (!resetn_in)
		serial_enable_out && wiper_wr_in |=> dac_code_out == $past(wiper_data_in);
	endproperty
	a_write: assert property (p_write) else $error("wiper write lost");

	property p_hold;
		@(posedge mclk_in) disable iff (!resetn_in)
		serial_enable_out && !wiper_wr_in |=> $stable(wiper_q);
	endproperty
	a_hold: assert property (p_hold) else $error("wiper changed without write");

	property p_quiet;
		@(posedge mclk_in) disable iff (!resetn_in)
		!serial_enable_out |-> !sda_oe_out && !interface_active_out;
	endproperty
	a_quiet: assert property (p_quiet) else $error("bus touched while disabled");

	property p_seq;
		@(posedge mclk_in) disable iff (!resetn_in)
		state_q == dprw_pkg::DPRW_OFF |=> state_q == dprw_pkg::DPRW_LOAD ##1 serial_enable_out;
	endproperty
	a_seq: assert property (p_seq) else $error("power-on sequence broken");

	// first edge that sees power-good high; the state is still OFF there
	sequence s_release;
		$rose(resetn_in) && state_q == dprw_pkg::DPRW_OFF;
	endsequence

	// defaults must show one clock after release, with the interface still shut
	property p_release;
		@(posedge mclk_in) disable iff (!resetn_in)
		s_release |=> shift_q == dprw_pkg::SHIFT_DEFAULT && wiper_q == dprw_pkg::WIPER_DEFAULT && !serial_enable_out;
	endproperty
	a_release: assert property (p_release) else $error("defaults late after power-good");

	// strobes seen during the load cycle must not touch the fresh defaults
	property p_after_load;
		@(posedge mclk_in) disable iff (!resetn_in)
		s_load |=> shift_q == dprw_pkg::SHIFT_DEFAULT && wiper_q == dprw_pkg::WIPER_DEFAULT;
	endproperty
	a_after_load: assert property (p_after_load) else $error("strobe taken during load");

	property p_shift;
		@(posedge mclk_in) disable iff (!resetn_in)
		serial_enable_out && shift_en_in |=> shift_q == {$past(shift_keep), $past(shift_bit_in)};
	endproperty
	a_shift: assert property (p_shift) else $error("shift register did not shift");

	property p_shift_hold;
		@(posedge mclk_in) disable iff (!resetn_in)
		serial_enable_out && !shift_en_in |=> $stable(shift_q);
	endproperty
	a_shift_hold: assert property (p_shift_hold) else $error("shift register moved without strobe");

	// stop has priority when both conditions land in one cycle while the interface is active; in static, start wins
	property p_both;
		@(posedge mclk_in) disable iff (!resetn_in)
		interface_active_out && start_seen_in && stop_seen_in |=> !interface_active_out;
	endproperty
	a_both: assert property (p_both) else $error("start and stop together left interface active");

	property p_active_hold;
		@(posedge mclk_in) disable iff (!resetn_in)
		interface_active_out && !stop_seen_in |=> interface_active_out;
	endproperty
	a_active_hold: assert property (p_active_hold) else $error("interface went static without stop");

	property p_static_hold;
		@(posedge mclk_in) disable iff (!resetn_in)
		serial_enable_out && !interface_active_out && !start_seen_in |=> !interface_active_out;
	endproperty
	a_static_hold: assert property (p_static_hold) else $error("interface woke without start");

	// only a power-good drop may shut the interface again
	property p_enable_stays;
		@(posedge mclk_in) disable iff (!resetn_in)
		serial_enable_out |=> serial_enable_out;
	endproperty
	a_enable_stays: assert property (p_enable_stays) else $error("interface disabled while powered");
endmodule
`default_nettype wire

// >>> sim/dprw_supply_model.sv
/* supply monitor model: turns a supply-ok flag into power-good.
 assumes the bench moves vdd_ok_in on clock edges. */
`timescale 1ns/10ps
`default_nettype none
module dprw_supply_model (
	input wire logic mclk_in,
	input wire logic vdd_ok_in,
	output logic pgood_out
);
	// drops at once, rises on a clock so reset release is synchronous
	always_ff @(posedge mclk_in or negedge vdd_ok_in) begin
		if (!vdd_ok_in) pgood_out <= 1'b0;
		else pgood_out <= 1'b1;
	end
endmodule
`default_nettype wire

// >>> sim/dprw_top_tb.sv
/* bench for dprw_top: power-up, strobe table, then brown-out and recovery cases.
 assumes the supply model drives power-good. */
`timescale 1ns/10ps
`default_nettype none
module dprw_top_tb;
	logic mclk_in = 0, vdd_ok = 0, pgood, wr = 0, sh = 0, bt = 0, st = 0, sp = 0, dl = 0;
	logic [6:0] wd = 7'h00;
	wire logic [6:0] shr, tap, dac;
	wire logic en, act, oe, sda;
	int err_total = 0, n_tests = 0;
	// wr, data, shift, bit, start, stop, tap, shift reg, active
	logic [26:0] rows [11] = '{{1'b1,7'h15,4'h0,7'h15,7'h40,1'b0}, {1'b0,7'h00,4'hC,7'h15,7'h01,1'b0},
		{1'b0,7'h00,4'h2,7'h15,7'h01,1'b1}, {1'b1,7'h7F,4'hC,7'h7F,7'h03,1'b1},
		{1'b0,7'h00,4'h1,7'h7F,7'h03,1'b0}, {1'b0,7'h00,4'h2,7'h7F,7'h03,1'b1},
		{1'b1,7'h0A,4'h8,7'h0A,7'h06,1'b1}, {1'b0,7'h00,4'h3,7'h0A,7'h06,1'b0},
		{1'b0,7'h00,4'h1,7'h0A,7'h06,1'b0}, {1'b0,7'h00,4'h3,7'h0A,7'h06,1'b1},
		{1'b0,7'h00,4'h1,7'h0A,7'h06,1'b0}};
	dprw_supply_model sup (.mclk_in(mclk_in), .vdd_ok_in(vdd_ok), .pgood_out(pgood));
	dprw_top uut (.mclk_in(mclk_in), .resetn_in(pgood), .start_seen_in(st), .stop_seen_in(sp),
		.shift_en_in(sh), .shift_bit_in(bt), .wiper_wr_in(wr), .wiper_data_in(wd), .sda_drive_low_in(dl),
		.serial_shift_register_out(shr), .output_tap_setting_out(tap), .dac_code_out(dac),
		.serial_enable_out(en), .interface_active_out(act), .sda_out(sda), .sda_oe_out(oe));
	initial begin
		forever #50 mclk_in = ~mclk_in;
	end
	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("tests=%0d errors=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// strobes left high are dropped only after the load cycle, so they must be ignored
	task automatic pwr_up;
		@(posedge mclk_in);
		vdd_ok <= 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		chk(shr, 7'h40);
		chk(tap, 7'h20);
		chk_bit(en, 1'b0);
		@(posedge mclk_in);
		{wr, st} <= 2'b00;
		#1;
		chk_bit(en, 1'b1);
		chk(tap, 7'h20);
		chk_bit(act, 1'b0);
	endtask
	initial begin
		repeat (12) @(posedge mclk_in);
		#1;
		chk_bit(en, 1'b0);
		chk_bit(sda, 1'b0);
		pwr_up;
		foreach (rows[i]) begin
			@(posedge mclk_in);
			{wr, wd, sh, bt, st, sp} <= rows[i][26:15];
			@(posedge mclk_in);
			{wr, sh, bt, st, sp} <= 5'h00;
			#1;
			chk(tap, rows[i][14:8]);
			chk(dac, rows[i][14:8]);
			chk(shr, rows[i][7:1]);
			chk_bit(act, rows[i][0]);
		end
		@(posedge mclk_in);
		dl <= 1'b1;
		#1;
		chk_bit(oe, 1'b1);
		chk_bit(sda, 1'b0);
		// the write cut by the drop is not checked: its result may be anything
		@(posedge mclk_in);
		vdd_ok <= 1'b0;
		wr <= 1'b1;
		wd <= 7'h55;
		#1;
		chk_bit(en, 1'b0);
		chk_bit(oe, 1'b0);
		@(posedge mclk_in);
		st <= 1'b1;
		pwr_up;
		chk_bit(act, 1'b0);
		summarize;
	end
	initial begin
		#20000;
		err_total++;
		summarize;
	end
endmodule
`default_nettype wire
